// ---- verilog/vtam_top.sv ----
// per-tributary receive vt alarm event gating with avalon-mm registers
// assumes defect inputs are synchronous levels and events one-cycle pulses
`timescale 1ns/1ps
module vtam_top
	import vtam_pkg::*;
#(
	parameter int unsigned TICK_CYC_P = TICK_CYC,
	parameter int unsigned AISF_SET_P = AISF_SET_TICKS,
	parameter int unsigned AISF_CLR_P = AISF_CLR_TICKS
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// defect and event indications from the de-mapper
	input wire logic size_err_i,
	input wire logic lop_i,
	input wire logic label_chg_i,
	input wire logic aisd_i,
	input wire logic rfi_i,
	input wire logic rdi_i,
	input wire logic es_ovf_i,
	input wire logic k4_aps_valid_i,
	input wire logic [APS_W-1:0] k4_aps_i,
	// results
	output logic vt_err_event_o,
	output logic size_err_comp_o,
	output logic aisf_o,
	output logic irq_o
);
	// bus handshake state
	logic wait_q;
	logic [31:0] rdata_q;
	logic req;
	logic wr_acc;
	logic [31:0] rd_mux;

	// software-owned configuration
	logic [7:0] alm_en_q;
	logic [7:0] prt_en_q;
	logic [EV_W-1:0] irq_mask_q;

	// write-one-to-clear strobes
	logic ovf_clr;
	logic aps_clr;
	logic [EV_W-1:0] irq_clr;

	// received aps tracking
	logic [APS_W-1:0] aps_q;
	logic aps_new;
	logic aps_chg;

	// overflow flag and failure timing
	logic ovf_flag;
	logic [TMR_W-1:0] div_q;
	logic tick_q;
	logic aisf;
	logic aisf_d1_q;

	// aggregation
	logic [7:0] cond;
	logic [7:0] cond_en;
	logic vt_err_d;
	logic vt_err_q;
	logic size_comp_q;

	// interrupt status
	logic [EV_W-1:0] irq_set;
	logic [EV_W-1:0] irq_stat;
	logic irq_q;

	// a request is taken on the edge where wait_q is high; the answer follows one cycle later
	assign req = avs_read_i | avs_write_i;
	assign wr_acc = avs_write_i & ~wait_q & avs_byteenable_i[0];

	// waitrequest drops for exactly one cycle per access, then rises again
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wait_q <= 1'b1;
		end
		else if (req && wait_q)
		begin
			wait_q <= 1'b0;
		end
		else
		begin
			wait_q <= 1'b1;
		end
	end

	// read data is captured before the answer so it stands at the sampling edge
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rdata_q <= RST_WORD;
		end
		else if (avs_read_i && wait_q)
		begin
			rdata_q <= rd_mux;
		end
	end

	// read multiplexer; unmapped addresses and reserved bits read as zero
	always_comb
	begin
		rd_mux = RST_WORD;
		case (avs_address_i)
			OFS_ALARM:
			begin
				rd_mux[7:0] = alm_en_q;
				rd_mux[ALM_OVF] = ovf_flag;
				rd_mux[ALM_AISF_DECL] = aisf;
			end
			OFS_PROT:
			begin
				rd_mux[7:0] = prt_en_q;
				rd_mux[PRT_APS_CHG] = aps_chg;
				rd_mux[PRT_APS_LSB +: APS_W] = aps_q;
			end
			OFS_IRQ_STAT:
			begin
				rd_mux[EV_W-1:0] = irq_stat;
			end
			OFS_IRQ_MASK:
			begin
				rd_mux[EV_W-1:0] = irq_mask_q;
			end
			default:
			begin
				rd_mux = RST_WORD;
			end
		endcase
	end

	// enable bits; read-only and clear-on-one positions are masked off
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			alm_en_q <= RST_BYTE;
			prt_en_q <= RST_BYTE;
		end
		else if (wr_acc && avs_address_i == OFS_ALARM)
		begin
			alm_en_q <= avs_writedata_i[7:0] & ALM_WR_MASK;
		end
		else if (wr_acc && avs_address_i == OFS_PROT)
		begin
			prt_en_q <= avs_writedata_i[7:0] & PRT_WR_MASK;
		end
	end

	// interrupt mask, same layout as the status
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			irq_mask_q <= '0;
		end
		else if (wr_acc && avs_address_i == OFS_IRQ_MASK)
		begin
			irq_mask_q <= avs_writedata_i[EV_W-1:0];
		end
	end

	// clear strobes from writes of one
	assign ovf_clr = wr_acc && avs_address_i == OFS_ALARM && avs_writedata_i[ALM_OVF];
	assign aps_clr = wr_acc && avs_address_i == OFS_PROT && avs_writedata_i[PRT_APS_CHG];
	assign irq_clr = (wr_acc && avs_address_i == OFS_IRQ_STAT) ? avs_writedata_i[EV_W-1:0] : '0;

	// sticky receive elastic-store overflow
	vtam_sticky #(
		.W(1)
	) u_ovf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.set_i(es_ovf_i),
		.clr_i(ovf_clr),
		.q_o(ovf_flag)
	);

	// only a validated value that differs from the held one counts as a change
	assign aps_new = k4_aps_valid_i && (k4_aps_i != aps_q);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			aps_q <= '0;
		end
		else if (aps_new)
		begin
			aps_q <= k4_aps_i;
		end
	end

	// sticky aps change
	vtam_sticky #(
		.W(1)
	) u_aps (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.set_i(aps_new),
		.clr_i(aps_clr),
		.q_o(aps_chg)
	);

	// millisecond enable; the persistence windows keep their tolerance with this grain
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
		end
		else if (div_q == TMR_W'(TICK_CYC_P - 1))
		begin
			div_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// ais-v failure declaration and clearing
	vtam_aisf_timer #(
		.SET_TICKS(TMR_W'(AISF_SET_P)),
		.CLR_TICKS(TMR_W'(AISF_CLR_P))
	) u_aisf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(tick_q),
		.defect_i(aisd_i),
		.fail_o(aisf)
	);

	// delayed copy for failure change detection
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			aisf_d1_q <= 1'b0;
		end
		else
		begin
			aisf_d1_q <= aisf;
		end
	end

	// conditions paired with their enables, same order in both vectors
	assign cond = {size_err_i, lop_i, label_chg_i, aisf, aisd_i, rfi_i, rdi_i, aps_new};
	assign cond_en = {alm_en_q[ALM_SIZE],
		alm_en_q[ALM_LOP],
		alm_en_q[ALM_LABEL],
		alm_en_q[ALM_AISF],
		alm_en_q[ALM_AISD],
		prt_en_q[PRT_RFI],
		prt_en_q[PRT_RDI],
		prt_en_q[PRT_APS_EN]};

	// overflow has no own enable, so only the master gates it
	assign vt_err_d = alm_en_q[ALM_MASTER] & ((|(cond & cond_en)) | es_ovf_i);

	// registered results
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			vt_err_q <= 1'b0;
			size_comp_q <= 1'b0;
		end
		else
		begin
			vt_err_q <= vt_err_d;
			size_comp_q <= size_err_i & alm_en_q[ALM_SIZE];
		end
	end

	// interrupt events: flag rising, overflow, aps change, failure declared or cleared
	always_comb
	begin
		irq_set = '0;
		irq_set[EV_VTERR] = vt_err_d & ~vt_err_q;
		irq_set[EV_OVF] = es_ovf_i;
		irq_set[EV_APS] = aps_new;
		irq_set[EV_AISF] = aisf ^ aisf_d1_q;
	end

	vtam_sticky #(
		.W(EV_W)
	) u_irq (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.q_o(irq_stat)
	);

	// level interrupt, one cycle behind the status
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |(irq_stat & irq_mask_q);
		end
	end

	// outputs straight from flip-flops
	assign avs_waitrequest_o = wait_q;
	assign avs_readdata_o = rdata_q;
	assign vt_err_event_o = vt_err_q;
	assign size_err_comp_o = size_comp_q;
	assign aisf_o = aisf;
	assign irq_o = irq_q;
endmodule

// ---- verilog/vtam_pkg.sv ----
// constants, register map and types of the vt alarm event mask block
// assumes a 10 MHz system clock and 32-bit avalon-mm register access
package vtam_pkg;
	// clock and timing base
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TICK_US = 1000; // one persistence tick per millisecond
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	// ais-v failure persistence, in milliseconds
	localparam int unsigned AISF_SET_MS = 2500;
	localparam int unsigned AISF_CLR_MS = 10000;
	localparam int unsigned AISF_SET_TICKS = AISF_SET_MS * 1000 / TICK_US;
	localparam int unsigned AISF_CLR_TICKS = AISF_CLR_MS * 1000 / TICK_US;
	localparam int unsigned TMR_W = 14;
	// register byte offsets
	localparam int unsigned ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_ALARM = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_PROT = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0C;
	// alarm enables and overflow register fields
	localparam int unsigned ALM_MASTER = 7;
	localparam int unsigned ALM_SIZE = 6;
	localparam int unsigned ALM_LOP = 5;
	localparam int unsigned ALM_LABEL = 4;
	localparam int unsigned ALM_OVF = 3;
	localparam int unsigned ALM_AISF = 2;
	localparam int unsigned ALM_AISF_DECL = 1;
	localparam int unsigned ALM_AISD = 0;
	localparam logic [7:0] ALM_WR_MASK = 8'hF5;
	// protection status and enables register fields
	localparam int unsigned PRT_RFI = 7;
	localparam int unsigned PRT_RDI = 6;
	localparam int unsigned PRT_APS_EN = 5;
	localparam int unsigned PRT_APS_CHG = 4;
	localparam int unsigned PRT_APS_LSB = 0;
	localparam int unsigned APS_W = 4;
	localparam logic [7:0] PRT_WR_MASK = 8'hE0;
	// interrupt event bits
	localparam int unsigned EV_VTERR = 0;
	localparam int unsigned EV_OVF = 1;
	localparam int unsigned EV_APS = 2;
	localparam int unsigned EV_AISF = 3;
	localparam int unsigned EV_W = 4;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// ais-v failure state
	typedef enum logic {AISF_CLEAR = 1'b0, AISF_DECLARED = 1'b1} vtam_aisf_t;
endpackage

// ---- verilog/vtam_sticky.sv ----
// sticky flag bank: set by hardware events, cleared by writing a one
// assumes set and clear pulses are synchronous to clk_i
`timescale 1ns/1ps
module vtam_sticky
	import vtam_pkg::*;
#(
	parameter int unsigned W = 1
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] q_o
);
	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			q_o <= '0;
		end
		else
		begin
			q_o <= (q_o & ~clr_i) | set_i;
		end
	end
endmodule

// ---- verilog/vtam_aisf_timer.sv ----
// ais-v failure persistence timer counting in millisecond ticks
// assumes tick_i is a one-cycle enable and defect_i is synchronous
`timescale 1ns/1ps
module vtam_aisf_timer
	import vtam_pkg::*;
#(
	parameter logic [TMR_W-1:0] SET_TICKS = TMR_W'(AISF_SET_TICKS),
	parameter logic [TMR_W-1:0] CLR_TICKS = TMR_W'(AISF_CLR_TICKS)
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic tick_i,
	input wire logic defect_i,
	output logic fail_o
);
	vtam_aisf_t state_q;
	logic [TMR_W-1:0] cnt_q;

	// any interruption of the awaited level restarts the count
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= AISF_CLEAR;
			cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				AISF_CLEAR:
				begin
					if (!defect_i)
						cnt_q <= '0;
					else if (tick_i && cnt_q == SET_TICKS - 1'b1)
					begin
						state_q <= AISF_DECLARED;
						cnt_q <= '0;
					end
					else if (tick_i)
						cnt_q <= cnt_q + 1'b1;
				end
				AISF_DECLARED:
				begin
					if (defect_i)
						cnt_q <= '0;
					else if (tick_i && cnt_q == CLR_TICKS - 1'b1)
					begin
						state_q <= AISF_CLEAR;
						cnt_q <= '0;
					end
					else if (tick_i)
						cnt_q <= cnt_q + 1'b1;
				end
				default:
				begin
					state_q <= AISF_CLEAR;
					cnt_q <= '0;
				end
			endcase
		end
	end

	assign fail_o = (state_q == AISF_DECLARED);
endmodule

// ---- tb/vtam_trib_model.sv ----
// tributary side model: defect levels and one-cycle event strobes
// assumes the bench raises each event request for exactly one cycle
`timescale 1ns/1ps
module vtam_trib_model
	import vtam_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [4:0] lvl_i,
	input wire logic [2:0] ev_i,
	input wire logic [APS_W-1:0] aps_i,
	output logic [4:0] lvl_o,
	output logic [2:0] ev_o,
	output logic [APS_W-1:0] aps_o
);
	// launched on the edge so the block never sees a mid-cycle change
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			lvl_o <= '0;
			ev_o <= '0;
			aps_o <= '0;
		end
		else
		begin
			lvl_o <= lvl_i;
			ev_o <= ev_i;
			aps_o <= ev_i[2] ? aps_i : ~aps_o; // value means nothing without its strobe
		end
	end
endmodule

// ---- tb/vtam_sva.sv ----
// port checker for the vt alarm event block
// assumes it is bound onto vtam_top with the same parameters
`timescale 1ns/1ps
module vtam_sva
	import vtam_pkg::*;
#(
	parameter int unsigned TICK_CYC_P = 4,
	parameter int unsigned AISF_SET_P = 5,
	parameter int unsigned AISF_CLR_P = 8
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic size_err_i,
	input wire logic lop_i,
	input wire logic label_chg_i,
	input wire logic aisd_i,
	input wire logic rfi_i,
	input wire logic rdi_i,
	input wire logic es_ovf_i,
	input wire logic k4_aps_valid_i,
	input wire logic vt_err_event_o,
	input wire logic size_err_comp_o,
	input wire logic aisf_o
);
	localparam int SETC = AISF_SET_P * TICK_CYC_P;
	localparam int CLRC = AISF_CLR_P * TICK_CYC_P;
	localparam int SLACK = TICK_CYC_P + 2;
	int hi_q;
	int lo_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// defect run lengths, saturated so a long run never wraps
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hi_q <= 0;
			lo_q <= 0;
		end
		else
		begin
			hi_q <= aisd_i ? (hi_q < 2 * CLRC ? hi_q + 1 : hi_q) : 0;
			lo_q <= aisd_i ? 0 : (lo_q < 2 * CLRC ? lo_q + 1 : lo_q);
		end
	end
	sequence take_s;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence one_low_s;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	bus_answer_a: assert property (take_s |=> one_low_s)
		else $error("bus answer not one cycle");
	read_upper_a: assert property (avs_readdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	size_comp_a: assert property (size_err_comp_o |-> $past(size_err_i))
		else $error("size composite without size error");
	vterr_cause_a: assert property (vt_err_event_o |-> $past(size_err_i || lop_i || label_chg_i || aisd_i
		|| rfi_i || rdi_i || es_ovf_i || k4_aps_valid_i || aisf_o)) else $error("vt error flag without cause");
	fail_early_a: assert property ($rose(aisf_o) |-> hi_q >= SETC - SLACK)
		else $error("failure declared too early");
	fail_late_a: assert property (hi_q == SETC + SLACK + 1 |-> aisf_o)
		else $error("failure declared too late");
	fail_hold_a: assert property (aisf_o && aisd_i |=> aisf_o)
		else $error("failure cleared under defect");
	clear_early_a: assert property ($fell(aisf_o) |-> lo_q >= CLRC - SLACK)
		else $error("failure cleared too early");
	clear_late_a: assert property (lo_q == CLRC + SLACK + 1 |-> !aisf_o)
		else $error("failure cleared too late");
endmodule
bind vtam_top vtam_sva #(.TICK_CYC_P(TICK_CYC_P), .AISF_SET_P(AISF_SET_P), .AISF_CLR_P(AISF_CLR_P)) u_sva (
	.clk_i, .rst_b_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .size_err_i, .lop_i,
	.label_chg_i, .aisd_i, .rfi_i, .rdi_i, .es_ovf_i, .k4_aps_valid_i, .vt_err_event_o, .size_err_comp_o, .aisf_o);

// ---- tb/tb_vt_demap_alarm_event_mask.sv ----
// self-checking bench: avalon-mm host tasks plus tributary model
// assumes shortened timing: 4-cycle tick, 5 ticks to declare, 8 to clear
`timescale 1ns/1ps
module tb_vt_demap_alarm_event_mask;
	import vtam_pkg::*;
	localparam int TK = 4;
	localparam int ST = 5;
	localparam int CL = 8;
	localparam logic [7:0] ENB [0:6] = '{8'h40, 8'h20, 8'h10, 8'h01, 8'h80, 8'h40, 8'h20};
	logic clk_i = 0;
	logic rst_b_i = 0;
	logic [ADDR_W-1:0] adr = '0;
	logic rd = 0;
	logic wr = 0;
	logic [31:0] wd = '0;
	logic [31:0] rdat;
	logic wreq;
	logic [4:0] lvl = '0;
	logic [2:0] ev = '0;
	logic [3:0] aps = '0;
	logic [4:0] lvl_s;
	logic [2:0] ev_s;
	logic [3:0] aps_s;
	logic vt_err;
	logic size_comp;
	logic aisf;
	logic irq;
	int num_errors = 0;
	int n_tests = 0;
	int n_vt = 0;
	int n_sc = 0;
	vtam_trib_model trib (.clk_i, .rst_b_i, .lvl_i(lvl), .ev_i(ev), .aps_i(aps), .lvl_o(lvl_s), .ev_o(ev_s),
		.aps_o(aps_s));
	vtam_top #(.TICK_CYC_P(TK), .AISF_SET_P(ST), .AISF_CLR_P(CL)) dut (.clk_i, .rst_b_i, .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .size_err_i(lvl_s[0]), .lop_i(lvl_s[1]), .label_chg_i(ev_s[0]),
		.aisd_i(lvl_s[2]), .rfi_i(lvl_s[3]), .rdi_i(lvl_s[4]), .es_ovf_i(ev_s[1]), .k4_aps_valid_i(ev_s[2]),
		.k4_aps_i(aps_s), .vt_err_event_o(vt_err), .size_err_comp_o(size_comp), .aisf_o(aisf), .irq_o(irq));
	// free-running clock, 100 ns
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	// cycles spent with each flag high, so short pulses are never missed
	always @(posedge clk_i)
	begin
		n_vt += (vt_err === 1'b1);
		n_sc += (size_comp === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one avalon-mm access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h00_0000, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wreq !== 1'b0 && n < 50);
		q = rdat;
		rd <= 0;
		wr <= 0;
		if (n >= 50)
			chk(0, 1);
	endtask
	task automatic wrt(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(0, a, 8'h00, q);
		chk(q, {24'h00_0000, e});
	endtask
	// k: 0 size, 1 lop, 2 label, 3 aisd, 4 rfi, 5 rdi, 6 aps change, 7 overflow
	task automatic fire(input int k);
		@(posedge clk_i);
		if (k == 2 || k > 5)
		begin
			ev <= (k == 2) ? 3'h1 : (k == 6) ? 3'h4 : 3'h2;
			aps <= aps + 4'h1;
		end
		else
			lvl <= 5'h01 << (k > 2 ? k - 1 : k);
		@(posedge clk_i);
		ev <= '0;
		repeat (2) @(posedge clk_i);
		lvl <= '0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic t_reset();
		rdc(OFS_ALARM, 8'h00);
		rdc(OFS_PROT, 8'h00);
		rdc(OFS_IRQ_STAT, 8'h00);
		rdc(OFS_IRQ_MASK, 8'h00);
		wrt(5'h10, 8'hFF);
		rdc(5'h10, 8'h00);
		wrt(OFS_ALARM, 8'hFF);
		rdc(OFS_ALARM, 8'hF5);
		wrt(OFS_PROT, 8'hFF);
		rdc(OFS_PROT, 8'hE0);
		wrt(OFS_ALARM, 8'h00);
		wrt(OFS_PROT, 8'h00);
	endtask
	task automatic t_enables();
		int b;
		int c;
		for (int k = 0; k < 7; k++)
			for (int e = 0; e < 2; e++)
			begin
				wrt(OFS_ALARM, 8'h80 | ((e == 1 && k < 4) ? ENB[k] : 8'h00));
				wrt(OFS_PROT, (e == 1 && k > 3) ? ENB[k] : 8'h00);
				b = n_vt;
				c = n_sc;
				fire(k);
				chk(32'(n_vt > b), 32'(e));
				if (k == 0)
					chk(32'(n_sc > c), 32'(e));
			end
		// master off: nothing may reach the flag
		wrt(OFS_ALARM, 8'h75);
		wrt(OFS_PROT, 8'hE0);
		b = n_vt;
		for (int k = 0; k < 8; k++)
			fire(k);
		chk(32'(n_vt > b), 0);
	endtask
	task automatic t_sticky();
		// clear flags left over from earlier scenarios so each set is really proven
		wrt(OFS_ALARM, 8'h08);
		wrt(OFS_PROT, 8'h10);
		fire(7);
		rdc(OFS_ALARM, 8'h08);
		wrt(OFS_ALARM, 8'h00);
		rdc(OFS_ALARM, 8'h08);
		wrt(OFS_ALARM, 8'h08);
		rdc(OFS_ALARM, 8'h00);
		fire(6);
		rdc(OFS_PROT, {4'h1, aps});
		wrt(OFS_PROT, 8'h1F);
		rdc(OFS_PROT, {4'h0, aps});
	endtask
	task automatic t_irq();
		wrt(OFS_IRQ_STAT, 8'h0F);
		wrt(OFS_IRQ_MASK, 8'h02);
		fire(7);
		chk(irq, 1);
		rdc(OFS_IRQ_STAT, 8'h02);
		wrt(OFS_IRQ_MASK, 8'h00);
		repeat (3) @(posedge clk_i);
		chk(irq, 0);
		wrt(OFS_IRQ_MASK, 8'h02);
		repeat (3) @(posedge clk_i);
		chk(irq, 1);
		wrt(OFS_IRQ_STAT, 8'h02);
		repeat (3) @(posedge clk_i);
		chk(irq, 0);
		// aps change event reaches its own status bit
		fire(6);
		rdc(OFS_IRQ_STAT, 8'h04);
	endtask
	task automatic t_aisf();
		int n;
		int b;
		// also clears the overflow flag left by the interrupt scenario
		wrt(OFS_ALARM, 8'h8C);
		b = n_vt;
		lvl <= 5'h04;
		for (n = 0; aisf !== 1'b1 && n < 100; n++)
			@(posedge clk_i);
		chk(32'(n >= ST * TK - TK - 2 && n <= ST * TK + TK + 2), 1);
		rdc(OFS_ALARM, 8'h86);
		chk(32'(n_vt > b), 1);
		lvl <= 5'h00;
		repeat (10) @(posedge clk_i);
		lvl <= 5'h04;
		repeat (3) @(posedge clk_i);
		chk(aisf, 1);
		lvl <= 5'h00;
		for (n = 0; aisf !== 1'b0 && n < 100; n++)
			@(posedge clk_i);
		chk(32'(n >= CL * TK - TK - 2 && n <= CL * TK + TK + 2), 1);
		rdc(OFS_ALARM, 8'h84);
		// flag rise and both failure changes, aps bit still held
		rdc(OFS_IRQ_STAT, 8'h0D);
	endtask
	// reset in mid-run must bring every register and output back to zero, except waitrequest, which returns high
	task automatic t_midrst();
		wrt(OFS_ALARM, 8'hFF);
		wrt(OFS_PROT, 8'hFF);
		wrt(OFS_IRQ_MASK, 8'h0F);
		fire(7);
		rdc(OFS_ALARM, 8'hFD);
		chk(irq, 1);
		rst_b_i <= 0;
		repeat (2) @(posedge clk_i);
		chk(wreq, 1);
		chk(rdat, 0);
		chk(irq, 0);
		rst_b_i <= 1;
		rdc(OFS_ALARM, 8'h00);
		rdc(OFS_PROT, 8'h00);
		rdc(OFS_IRQ_STAT, 8'h00);
		rdc(OFS_IRQ_MASK, 8'h00);
		chk(vt_err, 0);
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#2000000;
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1;
		t_reset();
		t_enables();
		t_sticky();
		t_irq();
		t_aisf();
		t_midrst();
		report_and_stop();
	end
endmodule
